// [logic/pcrc_top.sv]
`timescale 1ns/1ps
`include "pcrc_consts.svh"
// Summary of operation
// - Width field is bits minus one shifted
// - Length field minus one sets remainder width
// - Enable bit runs module, resets zero
// - Stop-in-idle halts module during Idle mode
// - Read-only counter tracks queued FIFO words
// - Narrow words: FIFO holds at most sixteen
// - Nine to sixteen bits: capacity eight
// - Seventeen to thirty-two bits: capacity four
// - Full flag reads one at capacity
// - Empty flag reads one when none queued
// - Select set: event when FIFO empties
// - Select clear: event after shifting completes
// - Start runs shifter; clearing aborts shifting
// - LSB-first select reflects input words
// - Mode bit picks alternate or legacy
// - Polynomial bits enable feedback terms
// - Polynomial bit zero always reads zero
// - Clear, set, invert aliases per register
// - Registers reset zero, control reads back empty flag set; unused bits zero
module pcrc_top #(
  parameter int FIFO_DEPTH = `PCRC_FIFO_DEPTH
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset_n,
  input  wire pcrc_pkg::pcrc_avs_req_t avs_req,
  output logic                        avs_waitrequest,
  output logic [31:0]                 avs_readdata,
  input  wire logic                   idle_mode,
  output logic                        irq_event
);
  import pcrc_pkg::*;

  generate
    if (FIFO_DEPTH != 16) begin : g_bad_depth
      $error("FIFO_DEPTH must be 16");
    end
  endgenerate

  function automatic logic [31:0] alias_op(input logic [31:0] old_v,
                                           input logic [31:0] wd,
                                           input logic [31:0] m,
                                           input logic [1:0]  op);
    logic [31:0] r;
    r = old_v;
    case (op)
      `PCRC_ALIAS_WR:  r = (old_v & ~m) | (wd & m);
      `PCRC_ALIAS_CLR: r = old_v & ~(wd & m);
      `PCRC_ALIAS_SET: r = old_v | (wd & m);
      `PCRC_ALIAS_INV: r = old_v ^ (wd & m);
      default:         r = old_v;
    endcase
    return r;
  endfunction

  // Register state
  logic [31:0]       ctrl_q;
  logic [31:0]       poly_q;
  logic [31:0]       data_q;
  logic [31:0]       crc_q;
  logic [31:0]       crc_d;
  logic              waitreq_q;
  logic [31:0]       rdata_q;
  logic              irq_q;
  logic              irq_cond_q;
  logic [31:0]       fifo_mem [0:15];
  logic [3:0]        wr_ptr_q;
  logic [3:0]        rd_ptr_q;
  logic [4:0]        count_q;
  logic [31:0]       sh_word_q;
  logic [4:0]        bits_left_q;
  pcrc_shift_state_t state_q;

  // Bus decode
  wire        req      = avs_req.read | avs_req.write;
  wire        in_block = avs_req.address[13:6] == `PCRC_BLOCK_BASE;
  wire [1:0]  reg_sel  = avs_req.address[5:4];
  wire [1:0]  alias_sel = avs_req.address[3:2];
  wire        take     = req & ~waitreq_q;
  wire        wr_take  = take & avs_req.write & in_block;
  wire [31:0] be_mask;
  generate
    for (genvar b = 0; b < 4; b++) begin : g_be
      assign be_mask[8*b +: 8] = {8{avs_req.byteenable[b]}};
    end
  endgenerate
  wire        wr_ctrl  = wr_take & (reg_sel == `PCRC_SEL_CTRL);
  wire        wr_poly  = wr_take & (reg_sel == `PCRC_SEL_POLY);
  wire        wr_data  = wr_take & (reg_sel == `PCRC_SEL_DATA);
  wire        wr_res   = wr_take & (reg_sel == `PCRC_SEL_RES);

  // Control fields
  wire [4:0] dw_f    = ctrl_q[`PCRC_DW_LSB +: 5];
  wire [4:0] pl_f    = ctrl_q[`PCRC_PL_LSB +: 5];
  wire       on_f    = ctrl_q[`PCRC_ON_BIT];
  wire       stop_in_idle_f  = ctrl_q[`PCRC_STOP_IN_IDLE_BIT];
  wire       isel_f  = ctrl_q[`PCRC_ISEL_BIT];
  wire       go_f    = ctrl_q[`PCRC_GO_BIT];
  wire       lsbf_f  = ctrl_q[`PCRC_LSBF_BIT];
  wire       mode_f  = ctrl_q[`PCRC_MODE_BIT];

  wire       halted  = ~on_f | (stop_in_idle_f & idle_mode);

  // Capacity follows data width
  wire [4:0] fifo_cap = (dw_f <= `PCRC_DW_NARROW_MAX) ? `PCRC_CAP_NARROW :
                        (dw_f <= `PCRC_DW_MID_MAX)    ? `PCRC_CAP_MID    :
                                                        `PCRC_CAP_WIDE;
  wire       fifo_full  = count_q >= fifo_cap;
  wire       fifo_empty = count_q == 5'h00;
  wire       busy       = state_q == SH_RUN;

  // Words offered while full are dropped
  wire       push = wr_data & ~fifo_full;
  wire       pop  = ~busy & go_f & ~halted & ~fifo_empty;
  wire       step = busy & go_f & ~halted;

  // Serial data bit and feedback
  wire        data_bit  = lsbf_f ? sh_word_q[0] : sh_word_q[dw_f];
  wire [31:0] len_mask  = 32'hFFFFFFFF >> (5'h1F - pl_f);
  wire        top_bit   = crc_q[pl_f];
  wire [31:0] poly_full = {poly_q[31:1], 1'b1};
  wire        fb_alt    = top_bit ^ data_bit;
  wire [31:0] next_alt  = ({crc_q[30:0], 1'b0} ^ (fb_alt ? poly_full : 32'h0)) & len_mask;
  wire [31:0] next_leg  = ({crc_q[30:0], data_bit} ^ (top_bit ? poly_full : 32'h0)) & len_mask;
  wire [31:0] crc_step  = mode_f ? next_alt : next_leg;

  // Readback assembly
  wire [31:0] ctrl_rd = (ctrl_q & `PCRC_CTRL_WMASK)
                      | {19'h0, count_q, fifo_full, fifo_empty, 6'h00};
  wire [31:0] poly_rd = poly_q & `PCRC_POLY_WMASK;
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    if (in_block) begin
      case (reg_sel)
        `PCRC_SEL_CTRL: rd_mux = ctrl_rd;
        `PCRC_SEL_POLY: rd_mux = poly_rd;
        `PCRC_SEL_DATA: rd_mux = data_q;
        `PCRC_SEL_RES:  rd_mux = crc_q;
        default:        rd_mux = 32'h00000000;
      endcase
    end
  end

  // Event source per select bit
  wire irq_cond = isel_f ? fifo_empty : (fifo_empty & ~busy);

  // Software write to the result wins over a shift step
  always_comb begin
    crc_d = crc_q;
    if (step) begin
      crc_d = crc_step;
    end
    if (wr_res) begin
      crc_d = alias_op(crc_q, avs_req.writedata, be_mask, alias_sel);
    end
  end

  // Bus handshake: one wait cycle, then answer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      waitreq_q <= 1'b1;
      rdata_q   <= 32'h00000000;
    end else begin
      waitreq_q <= ~(req & waitreq_q);
      if (req & waitreq_q) begin
        rdata_q <= avs_req.read ? rd_mux : 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `PCRC_REG_RESET;
      poly_q <= `PCRC_REG_RESET;
      data_q <= `PCRC_REG_RESET;
      crc_q  <= `PCRC_REG_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= alias_op(ctrl_q, avs_req.writedata,
                           be_mask & `PCRC_CTRL_WMASK, alias_sel);
      end
      if (wr_poly) begin
        poly_q <= alias_op(poly_q, avs_req.writedata,
                           be_mask & `PCRC_POLY_WMASK, alias_sel);
      end
      if (wr_data) begin
        data_q <= alias_op(data_q, avs_req.writedata, be_mask, alias_sel);
      end
      crc_q <= crc_d;
    end
  end

  // FIFO storage; data is the aliased value of the written word
  wire [31:0] push_word = alias_op(data_q, avs_req.writedata, be_mask, alias_sel);
  always_ff @(posedge core_clk) begin
    if (push) begin
      fifo_mem[wr_ptr_q] <= push_word;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= 4'h0;
      rd_ptr_q <= 4'h0;
      count_q  <= 5'h00;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
      case ({push, pop})
        2'b10:   count_q <= count_q + 5'h01;
        2'b01:   count_q <= count_q - 5'h01;
        default: count_q <= count_q;
      endcase
    end
  end

  // Serial shifter: one bit per cycle, halt freezes, clearing start aborts
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q     <= SH_IDLE;
      sh_word_q   <= 32'h00000000;
      bits_left_q <= 5'h00;
    end else begin
      case (state_q)
        SH_IDLE: begin
          if (pop) begin
            state_q     <= SH_RUN;
            sh_word_q   <= fifo_mem[rd_ptr_q];
            bits_left_q <= dw_f;
          end
        end
        SH_RUN: begin
          if (!go_f) begin
            state_q <= SH_IDLE;
          end else if (step) begin
            sh_word_q   <= lsbf_f ? {1'b0, sh_word_q[31:1]} : {sh_word_q[30:0], 1'b0};
            bits_left_q <= bits_left_q - 5'h01;
            if (bits_left_q == 5'h00) begin
              state_q <= SH_IDLE;
            end
          end
        end
        default: state_q <= SH_IDLE;
      endcase
    end
  end

  // Edge of the selected condition gives a one-cycle event
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_cond_q <= 1'b1;
      irq_q      <= 1'b0;
    end else begin
      irq_cond_q <= irq_cond;
      irq_q      <= irq_cond & ~irq_cond_q;
    end
  end

  assign avs_waitrequest = waitreq_q;
  assign avs_readdata    = rdata_q;
  assign irq_event       = irq_q;

  // Checks
  a_push_count: assert property (@(posedge core_clk) disable iff (!reset_n)
    push && !pop |=> count_q == $past(count_q) + 5'h01)
    else $error("count did not rise on push");

  a_pop_count: assert property (@(posedge core_clk) disable iff (!reset_n)
    pop && !push |=> count_q == $past(count_q) - 5'h01)
    else $error("count did not fall on pop");

  a_count_max: assert property (@(posedge core_clk) disable iff (!reset_n)
    count_q <= `PCRC_CAP_NARROW)
    else $error("count above sixteen");

  a_mid_cap: assert property (@(posedge core_clk) disable iff (!reset_n)
    dw_f > `PCRC_DW_NARROW_MAX && dw_f <= `PCRC_DW_MID_MAX && count_q >= 5'h08 |-> !push)
    else $error("push beyond eight words");

  a_wide_cap: assert property (@(posedge core_clk) disable iff (!reset_n)
    dw_f > `PCRC_DW_MID_MAX && count_q >= 5'h04 |-> !push)
    else $error("push beyond four words");

  a_word_load: assert property (@(posedge core_clk) disable iff (!reset_n)
    pop |=> busy && bits_left_q == $past(dw_f))
    else $error("shifter not loaded with width");

  a_go_abort: assert property (@(posedge core_clk) disable iff (!reset_n)
    !go_f |=> !busy)
    else $error("shifter ran without start");

  a_halt_freeze: assert property (@(posedge core_clk) disable iff (!reset_n)
    busy && halted && go_f && !wr_res |=> bits_left_q == $past(bits_left_q)
      && crc_q == $past(crc_q))
    else $error("shifter moved while halted");

  a_len_mask: assert property (@(posedge core_clk) disable iff (!reset_n)
    step && !wr_res |=> (crc_q & ~$past(len_mask)) == 32'h0)
    else $error("remainder exceeds polynomial length");

  a_empty_event: assert property (@(posedge core_clk) disable iff (!reset_n)
    isel_f && fifo_empty && !irq_cond_q |=> irq_q)
    else $error("no event on FIFO empty");

  a_done_event: assert property (@(posedge core_clk) disable iff (!reset_n)
    irq_q && !$past(isel_f) |-> $past(fifo_empty && !busy))
    else $error("event before shifting done");

  a_bus_answer: assert property (@(posedge core_clk) disable iff (!reset_n)
    req && waitreq_q |=> !waitreq_q ##1 waitreq_q)
    else $error("bus answer not one cycle");

  a_step_count: assert property (@(posedge core_clk) disable iff (!reset_n)
    step && bits_left_q != 5'h00 |=> bits_left_q == $past(bits_left_q) - 5'h01)
    else $error("bit count did not fall on step");

  a_bits_end: assert property (@(posedge core_clk) disable iff (!reset_n)
    step && bits_left_q == 5'h00 |=> !busy)
    else $error("shifter ran past word width");

  a_full_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_data && fifo_full && !pop |=> count_q == $past(count_q))
    else $error("word pushed into full FIFO");

  a_full_mid: assert property (@(posedge core_clk) disable iff (!reset_n)
    dw_f > `PCRC_DW_NARROW_MAX && dw_f <= `PCRC_DW_MID_MAX
      && count_q == `PCRC_CAP_MID |-> fifo_full)
    else $error("full flag low at capacity");

  a_empty_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
    count_q == 5'h00 |-> fifo_empty && !fifo_full)
    else $error("empty flag wrong with no words");

  a_poly_bit0: assert property (@(posedge core_clk) disable iff (!reset_n)
    poly_q[0] == 1'b0)
    else $error("polynomial bit zero stored");

  a_ctrl_unused: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ctrl_q & ~`PCRC_CTRL_WMASK) == 32'h00000000)
    else $error("unused control bit stored");

  a_rd_unmapped: assert property (@(posedge core_clk) disable iff (!reset_n)
    req && waitreq_q && !in_block |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");

  a_irq_pulse: assert property (@(posedge core_clk) disable iff (!reset_n)
    irq_q |=> !irq_q)
    else $error("event longer than one cycle");

  a_idle_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    stop_in_idle_f && idle_mode |-> !pop && !step)
    else $error("shifter active in idle stop");

  a_off_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
    !on_f |-> !pop && !step)
    else $error("shifter active while disabled");

  c_fill_full: cover property (@(posedge core_clk) disable iff (!reset_n)
    fifo_full && wr_data);
  c_irq_seen: cover property (@(posedge core_clk) disable iff (!reset_n)
    irq_q);
  c_abort: cover property (@(posedge core_clk) disable iff (!reset_n)
    busy && !go_f);
  c_word_done: cover property (@(posedge core_clk) disable iff (!reset_n)
    step && bits_left_q == 5'h00);
  c_lsb_run: cover property (@(posedge core_clk) disable iff (!reset_n)
    step && lsbf_f);

endmodule

// [logic/pcrc_consts.svh]
`ifndef PCRC_CONSTS_SVH
`define PCRC_CONSTS_SVH

// Register base byte addresses
`define PCRC_ADDR_W        14
`define PCRC_CTRL_OFS      14'h0A00
`define PCRC_POLY_OFS      14'h0A10
`define PCRC_DATA_OFS      14'h0A20
`define PCRC_RES_OFS       14'h0A30
`define PCRC_BLOCK_BASE    8'h28

// Alias selector in address bits 3:2
`define PCRC_ALIAS_WR      2'h0
`define PCRC_ALIAS_CLR     2'h1
`define PCRC_ALIAS_SET     2'h2
`define PCRC_ALIAS_INV     2'h3

// Register select in address bits 5:4
`define PCRC_SEL_CTRL      2'h0
`define PCRC_SEL_POLY      2'h1
`define PCRC_SEL_DATA      2'h2
`define PCRC_SEL_RES       2'h3

// Control field positions
`define PCRC_DW_LSB        24
`define PCRC_PL_LSB        16
`define PCRC_ON_BIT        15
`define PCRC_STOP_IN_IDLE_BIT      13
`define PCRC_CNT_LSB       8
`define PCRC_FULL_BIT      7
`define PCRC_EMPTY_BIT     6
`define PCRC_ISEL_BIT      5
`define PCRC_GO_BIT        4
`define PCRC_LSBF_BIT      3
`define PCRC_MODE_BIT      2

// Writable masks and reset values
`define PCRC_CTRL_WMASK    32'h1F1FA03C
`define PCRC_POLY_WMASK    32'hFFFFFFFE
`define PCRC_REG_RESET     32'h00000000

// FIFO capacities by data width
`define PCRC_FIFO_DEPTH    16
`define PCRC_CAP_NARROW    5'h10
`define PCRC_CAP_MID       5'h08
`define PCRC_CAP_WIDE      5'h04
`define PCRC_DW_NARROW_MAX 5'h07
`define PCRC_DW_MID_MAX    5'h0F

`endif

// [logic/pcrc_pkg.sv]
package pcrc_pkg;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [13:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } pcrc_avs_req_t;

  typedef enum logic [1:0] {
    SH_IDLE = 2'b01,
    SH_RUN  = 2'b10
  } pcrc_shift_state_t;

endpackage

// [dv/pcrc_tb.sv]
`timescale 1ns/1ps
`include "pcrc_consts.svh"
module programmable_crc_generator_tb_top;
  import pcrc_pkg::*;
  localparam logic [13:0] CT = `PCRC_CTRL_OFS;
  localparam logic [13:0] PL = `PCRC_POLY_OFS;
  localparam logic [13:0] DA = `PCRC_DATA_OFS;
  localparam logic [13:0] RS = `PCRC_RES_OFS;
  logic          core_clk;
  logic          reset_n;
  logic          idle_mode;
  pcrc_avs_req_t req;
  logic          wt;
  logic          irq;
  logic [31:0]   rdat;
  logic [31:0]   q;
  int            n_mismatch;
  int            cmp_count;

  pcrc_top #(.FIFO_DEPTH(16)) i_dut (
    .core_clk        (core_clk),
    .reset_n         (reset_n),
    .avs_req         (req),
    .avs_waitrequest (wt),
    .avs_readdata    (rdat),
    .idle_mode       (idle_mode),
    .irq_event       (irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Request held up to the rising edge that samples waitrequest low; data taken there
  task automatic bus(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    req <= '{read: ~w, write: w, address: a, writedata: d, byteenable: 4'hF};
    do begin
      @(posedge core_clk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    if (wt !== 1'b0) chk(32'h0, 32'h1);
    q = rdat;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wirq(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (irq !== 1'b1 && n < 300);
    if (n >= 300) chk(32'h0, 32'h1);
  endtask

  task automatic drain;
    int n;
    n = 0;
    do begin
      bus(1'b0, CT, 32'h0);
      n++;
    end while (!q[6] && n < 100);
    chk(32'(q[12:6]), 32'h01);
  endtask

  function automatic logic [31:0] cv(int w, int c, int f);
    return 32'((w << 24) | (c << 8) | (f << 7) | ((c == 0) << 6));
  endfunction

  // Bit-serial reference: alternate feeds data xor top bit, legacy appends data
  function automatic logic [31:0] crc(logic [31:0] r, logic [31:0] d, int w, int l,
                                      logic [31:0] p, logic alt, logic lsb);
    logic b;
    logic t;
    for (int i = 0; i < w; i++) begin
      b = lsb ? d[i] : d[w-1-i];
      t = r[l-1];
      r = alt ? {r[30:0], 1'b0} : {r[30:0], b};
      if (alt ? (b ^ t) : t) r = r ^ (p | 32'h1);
      r = r & ((l == 32) ? 32'hFFFFFFFF : ((32'h1 << l) - 32'h1));
    end
    return r;
  endfunction

  task automatic t_regs;
    bus(1'b0, CT, 32'h0); chk(q, 32'h00000040);
    bus(1'b0, PL, 32'h0); chk(q, 32'h0);
    bus(1'b0, RS, 32'h0); chk(q, 32'h0);
    bus(1'b1, PL, 32'hFFFFFFFF);
    bus(1'b0, PL, 32'h0); chk(q, 32'hFFFFFFFE);
    bus(1'b1, PL, 32'h0000F0F0);
    bus(1'b1, PL + 14'h8, 32'h0F000001);
    bus(1'b1, PL + 14'hC, 32'hFF0000FF);
    bus(1'b1, PL + 14'h4, 32'hF0000000);
    bus(1'b0, PL, 32'h0); chk(q, 32'h0000F00E);
    bus(1'b1, 14'h0B10, 32'hFFFFFFFF);
    bus(1'b0, 14'h0B10, 32'h0); chk(q, 32'h0);
    bus(1'b0, PL, 32'h0); chk(q, 32'h0000F00E);
    bus(1'b1, CT, 32'hFFFFFFFF);
    bus(1'b0, CT, 32'h0); chk(q, 32'h1F1FA07C);
    bus(1'b1, CT + 14'h4, 32'hFFFFFFFF);
    bus(1'b0, CT, 32'h0); chk(q, 32'h00000040);
    bus(1'b1, RS, 32'h12345678);
    bus(1'b0, RS, 32'h0); chk(q, 32'h12345678);
  endtask

  task automatic t_fifo;
    int w[3] = '{7, 15, 31};
    int c[3] = '{16, 8, 4};
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, CT, 32'(w[k] << 24));
      for (int i = 0; i <= c[k]; i++) begin
        bus(1'b1, DA, 32'(i + 1));
        if (i >= c[k] - 2) begin
          bus(1'b0, CT, 32'h0);
          chk(q, cv(w[k], (i < c[k]) ? i + 1 : c[k], i + 1 >= c[k]));
        end
      end
      bus(1'b1, CT + 14'h8, 32'h00008010);
      drain();
      bus(1'b0, DA, 32'h0); chk(q, 32'(c[k] + 1));
      bus(1'b1, CT, 32'h0);
    end
  endtask

  task automatic hold(input logic [31:0] e);
    repeat (30) @(posedge core_clk);
    bus(1'b0, CT, 32'h0);
    chk(32'(q[12:8]), e);
  endtask

  task automatic t_halt;
    bus(1'b1, CT, 32'h07008000);
    bus(1'b1, DA, 32'h11);
    bus(1'b1, DA, 32'h22);
    hold(32'h2);
    bus(1'b1, CT, 32'h07002010);
    hold(32'h2);
    idle_mode <= 1'b1;
    bus(1'b1, CT + 14'h8, 32'h00008000);
    hold(32'h2);
    idle_mode <= 1'b0;
    drain();
    bus(1'b1, CT, 32'h0);
  endtask

  task automatic t_crc;
    logic [31:0] e;
    int          n;
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, CT, {8'h0B, 8'h0F, 12'h0, m[0], m[1], 2'b00});
      bus(1'b1, PL, 32'h00001021);
      bus(1'b1, RS, 32'h0000FFFF);
      bus(1'b1, DA, 32'h00000A5C);
      bus(1'b1, DA, 32'h000003C1);
      e = crc(32'hFFFF, 32'hA5C, 12, 16, 32'h1020, m[1], m[0]);
      e = crc(e, 32'h3C1, 12, 16, 32'h1020, m[1], m[0]);
      bus(1'b1, CT + 14'h8, 32'h00008010);
      wirq(n);
      bus(1'b0, RS, 32'h0); chk(q, e);
      bus(1'b1, CT, 32'h0);
    end
  endtask

  // One 32-bit word: only the shift-complete event waits for all its bits
  task automatic t_irq;
    int n[2];
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, CT, 32'h1F1F0000 | 32'(s << 5));
      bus(1'b1, DA, 32'hC0FFEE01);
      bus(1'b1, CT + 14'h8, 32'h00008010);
      wirq(n[s]);
      bus(1'b1, CT, 32'h0);
    end
    chk(32'(n[1] <= 4), 32'h1);
    chk(32'(n[0] >= 32 && n[0] <= 40), 32'h1);
  endtask

  task automatic end_of_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #800000;
    n_mismatch++;
    end_of_test();
  end

  initial begin
    reset_n = 1'b0;
    idle_mode = 1'b0;
    req = '0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    t_regs();
    t_fifo();
    t_halt();
    t_crc();
    t_irq();
    end_of_test();
  end
endmodule
